// ### design/tec0_top.sv
// Timer/event counter 0: 8-bit up-counter with preload, three modes,
// prescaled slow clock, Avalon-MM register slave.
// Assumes oscillator and timer pins are asynchronous and slow
// compared with REF_CLK; clock options are static straps.
//
// Notes on behaviour
// RULE_01: 8-bit up-counter fed by pin, system clock over 4, or slow clock.
// RULE_02: Slow source chosen by option, divided by 16 then by the prescaler.
// RULE_03: Control bits 2..0 pick divide 32 up to 4096, doubling per code.
// RULE_04: An option, not a register bit, picks sys/4 or slow clock internally.
// RULE_05: Count write goes to preload; count read returns counter contents.
// RULE_06: Bits 7..6: 01 event, 10 timer, 11 pulse width, 00 unused.
// RULE_07: Event mode counts pin edges, falling if bit 3 set, else rising.
// RULE_08: Timer mode counts once per internal clock period while enabled.
// RULE_09: Event and timer modes count up from current value to FFH.
// RULE_10: Overflow past FFH reloads preload and sets flag bit 5 together.
// RULE_11: Pulse mode counts from start edge to return level, then clears enable.
// RULE_12: Finished measurement holds; rearmed only by setting enable again.
// RULE_13: Pulse counting starts on a transition, never on a standing level.
// RULE_14: Overflow in pulse mode reloads and raises request as elsewhere.
// RULE_15: Bit 4 enables; only software clears it in event and timer modes.
// RULE_16: Counter overflow is a wake-up source ending halt.
// RULE_17: Clearing the interrupt enable blocks the timer interrupt in any mode.
// RULE_18: Write while disabled loads both preload and counter.
// RULE_19: Write while enabled updates preload only; counter reloads later.
// RULE_20: Reading the counter blocks counting; lost counts are software's care.
// RULE_21: Control bit 5 is unused and reads zero.
// RULE_22: Timer pin is synchronised before edge detection.
//
// Local design decision: register access over Avalon-MM.
`timescale 1ns/1ns
module tec0_top
   import tec0_pkg::*;
(
   input wire logic REF_CLK,
   input wire logic RESETN,
   input wire logic [tec0_pkg::TEC0_AW-1:0] ADDRESS,
   input wire logic READ,
   input wire logic WRITE,
   input wire logic [tec0_pkg::TEC0_DW-1:0] WRITEDATA,
   input wire logic [3:0] BYTEENABLE,
   output logic [tec0_pkg::TEC0_DW-1:0] READDATA,
   output logic WAITREQUEST,
   input wire logic TIMER_PIN,
   input wire logic WATCHDOG_OSCILLATOR_IN,
   input wire logic RTC_IN,
   input wire logic [1:0] CFG_SLOW_SRC,
   input wire logic CFG_INT_SLOW,
   output logic IRQ_REQ,
   output logic WAKEUP
);
   import tec0_pkg::*;

   // =====================================================================
   // State
   tec0_state_s st_r;
   tec0_state_s st_nxt;

   logic bus_done;
   logic wr_cnt;
   logic wr_ctl;
   logic wr_irq;
   logic rd_cnt_block;
   logic sys4_tick;
   logic slow_tick;
   logic fsp_tick;
   logic int_tick;
   logic pin_rise;
   logic pin_fall;
   logic ev_tick;
   logic ovf;
   logic [15:0] psc_mask;
   logic [7:0] ctl_view;
   logic [7:0] irq_view;

   // =====================================================================
   // Bus decode
   assign bus_done = (READ || WRITE) && !st_r.wait_q;
   assign wr_cnt = WRITE && bus_done && BYTEENABLE[0] && (ADDRESS == TEC0_ADDR_COUNT);
   assign wr_ctl = WRITE && bus_done && BYTEENABLE[0] && (ADDRESS == TEC0_ADDR_CTRL);
   assign wr_irq = WRITE && bus_done && BYTEENABLE[0] && (ADDRESS == TEC0_ADDR_IRQCTL);
   // RULE_20: clock blocked through read
   // Held for both cycles of the read so the sampled byte is coherent.
   assign rd_cnt_block = READ && (ADDRESS == TEC0_ADDR_COUNT);

   // RULE_21: bit 5 reads zero
   assign ctl_view = {st_r.mode, 1'b0, st_r.cnt_en, st_r.edge_sel, st_r.psc};
   assign irq_view = {2'h0, st_r.irq_flag, 2'h0, st_r.irq_en, 2'h0};

   // =====================================================================
   // Clock sources
   // RULE_04: internal source by option
   assign sys4_tick = (st_r.div4 == TEC0_SYS_DIV_LAST);

   // RULE_02: slow source by option
   always_comb begin
      case (CFG_SLOW_SRC)
         TEC0_SLOW_WDT: slow_tick = st_r.wdt_s[2] && !st_r.wdt_f && (st_r.wdt_s[1] == st_r.wdt_s[2]);
         TEC0_SLOW_RTC: slow_tick = st_r.rtc_s[2] && !st_r.rtc_f && (st_r.rtc_s[1] == st_r.rtc_s[2]);
         TEC0_SLOW_INSTR: slow_tick = sys4_tick;
         default: slow_tick = 1'b0;
      endcase
   end

   // RULE_03: divide 32 to 4096
   // Mask spans 9 bits at code 000 (16 x 32), one more per code.
   assign psc_mask = TEC0_PSC_MASK_MAX >> (TEC0_PSC_CODE_MAX - st_r.psc);
   assign fsp_tick = slow_tick && ((st_r.slow_cnt & psc_mask) == psc_mask);
   assign int_tick = CFG_INT_SLOW ? fsp_tick : sys4_tick;

   // RULE_22: edges from filtered pin
   assign pin_rise = (st_r.pin_s[1] == st_r.pin_s[2]) && st_r.pin_s[2] && !st_r.pin_f;
   assign pin_fall = (st_r.pin_s[1] == st_r.pin_s[2]) && !st_r.pin_s[2] && st_r.pin_f;

   // =====================================================================
   // Counting tick per mode
   // RULE_06: mode decode
   always_comb begin
      ev_tick = 1'b0;
      case (st_r.mode)
         // RULE_07: edge-selected event count
         TEC0_MODE_EVENT: ev_tick = st_r.cnt_en && (st_r.edge_sel ? pin_fall : pin_rise);
         // RULE_08: one count per period
         TEC0_MODE_TIMER: ev_tick = st_r.cnt_en && int_tick;
         TEC0_MODE_PULSE: ev_tick = st_r.cnt_en && (st_r.pw == PW_COUNT) && int_tick;
         default: ev_tick = 1'b0;
      endcase
      if (rd_cnt_block) begin
         ev_tick = 1'b0;
      end
   end

   // RULE_09: count up to FFH
   assign ovf = ev_tick && (st_r.count == TEC0_COUNT_MAX);

   // =====================================================================
   // Next state
   always_comb begin
      st_nxt = st_r;
      // Synchronisers: first stage feeds only the second
      st_nxt.pin_s = {st_r.pin_s[1:0], TIMER_PIN};
      st_nxt.wdt_s = {st_r.wdt_s[1:0], WATCHDOG_OSCILLATOR_IN};
      st_nxt.rtc_s = {st_r.rtc_s[1:0], RTC_IN};
      if (st_r.pin_s[1] == st_r.pin_s[2]) begin
         st_nxt.pin_f = st_r.pin_s[2];
      end
      if (st_r.wdt_s[1] == st_r.wdt_s[2]) begin
         st_nxt.wdt_f = st_r.wdt_s[2];
      end
      if (st_r.rtc_s[1] == st_r.rtc_s[2]) begin
         st_nxt.rtc_f = st_r.rtc_s[2];
      end
      st_nxt.div4 = st_r.div4 + 2'h1;
      // RULE_02: divide by 16, then prescaler
      if (slow_tick) begin
         st_nxt.slow_cnt = st_r.slow_cnt + 16'h0001;
      end

      // RULE_01: 8-bit up-counter
      st_nxt.wake = 1'b0;
      if (ev_tick) begin
         if (ovf) begin
            // RULE_10: reload and flag together
            // RULE_14: same in pulse mode
            st_nxt.count = st_r.preload;
            st_nxt.wake = 1'b1;
         end else begin
            st_nxt.count = st_r.count + 8'h01;
         end
      end

      // Pulse width measurement
      if (st_r.mode != TEC0_MODE_PULSE || !st_r.cnt_en) begin
         st_nxt.pw = PW_WAIT;
      end else begin
         case (st_r.pw)
            PW_WAIT: begin
               // RULE_13: start on a transition only
               if (st_r.edge_sel ? pin_rise : pin_fall) begin
                  st_nxt.pw = PW_COUNT;
               end
            end
            PW_COUNT: begin
               // RULE_11: stop on return, clear enable
               // RULE_12: result held until re-enabled
               if (st_r.edge_sel ? pin_fall : pin_rise) begin
                  st_nxt.pw = PW_WAIT;
                  st_nxt.cnt_en = 1'b0;
               end
            end
            default: st_nxt.pw = PW_WAIT;
         endcase
      end

      // Software writes
      if (wr_cnt) begin
         // RULE_05: write goes to preload
         // RULE_19: running counter keeps going
         st_nxt.preload = WRITEDATA[7:0];
         // RULE_18: disabled write loads counter
         if (!st_r.cnt_en) begin
            st_nxt.count = WRITEDATA[7:0];
         end
      end
      if (wr_ctl) begin
         st_nxt.psc = WRITEDATA[TEC0_CTL_PSC_MSB:TEC0_CTL_PSC_LSB];
         st_nxt.edge_sel = WRITEDATA[TEC0_CTL_EDGE_BIT];
         // RULE_15: software owns the enable
         st_nxt.cnt_en = WRITEDATA[TEC0_CTL_EN_BIT];
         st_nxt.mode = WRITEDATA[TEC0_CTL_MODE_MSB:TEC0_CTL_MODE_LSB];
      end
      if (wr_irq) begin
         st_nxt.irq_en = WRITEDATA[TEC0_IRQ_EN_BIT];
         st_nxt.irq_flag = WRITEDATA[TEC0_IRQ_FLAG_BIT];
      end
      // Set beats a clear in the same cycle
      if (ovf) begin
         st_nxt.irq_flag = 1'b1;
      end
      // RULE_17: enable gates the request
      st_nxt.irq_out = st_nxt.irq_flag && st_nxt.irq_en;

      // Avalon: one wait cycle, data latched on the first edge
      if (st_r.wait_q) begin
         if (READ || WRITE) begin
            st_nxt.wait_q = 1'b0;
            case (ADDRESS)
               // RULE_05: read returns the counter
               TEC0_ADDR_COUNT: st_nxt.rdata = st_r.count;
               TEC0_ADDR_CTRL: st_nxt.rdata = ctl_view;
               TEC0_ADDR_IRQCTL: st_nxt.rdata = irq_view;
               default: st_nxt.rdata = 8'h00;
            endcase
         end
      end else begin
         st_nxt.wait_q = 1'b1;
      end
   end

   // =====================================================================
   // Registers
   always_ff @(posedge REF_CLK or negedge RESETN) begin
      if (!RESETN) begin
         st_r <= '0;
         st_r.count <= TEC0_COUNT_RESET;
         st_r.preload <= TEC0_COUNT_RESET;
         st_r.mode <= TEC0_CTRL_RESET[TEC0_CTL_MODE_MSB:TEC0_CTL_MODE_LSB];
         st_r.edge_sel <= TEC0_CTRL_RESET[TEC0_CTL_EDGE_BIT];
         st_r.cnt_en <= TEC0_CTRL_RESET[TEC0_CTL_EN_BIT];
         st_r.psc <= TEC0_CTRL_RESET[TEC0_CTL_PSC_MSB:TEC0_CTL_PSC_LSB];
         st_r.pw <= PW_WAIT;
         st_r.wait_q <= 1'b1;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign READDATA = {24'h000000, st_r.rdata};
   assign WAITREQUEST = st_r.wait_q;
   assign IRQ_REQ = st_r.irq_out;
   // RULE_16: overflow wakes the core
   assign WAKEUP = st_r.wake;

   // =====================================================================
   // Checks
   default clocking cb @(posedge REF_CLK);
   endclocking
   default disable iff (!RESETN);

   // RULE_10: reload value and flag
   a_ovf_reload: assert property (st_r.wake |-> st_r.count == $past(st_r.preload)
      && st_r.irq_flag) else $error("overflow did not reload or flag"); // RULE_10
   // RULE_09: wrap only from FFH
   a_ovf_from_max: assert property (st_r.wake |-> $past(st_r.count) == 8'hFF)
      else $error("overflow from value other than FFH"); // RULE_09
   // RULE_17: request gated by enable
   a_irq_gated: assert property (st_r.irq_out == (st_r.irq_flag && st_r.irq_en))
      else $error("interrupt request not gated by enable"); // RULE_17
   // RULE_18: disabled write loads counter
   a_wr_off_load: assert property (wr_cnt && !st_r.cnt_en
      |=> st_r.count == $past(WRITEDATA[7:0]) && st_r.preload == $past(WRITEDATA[7:0]))
      else $error("disabled write did not load counter"); // RULE_18
   // RULE_19: enabled write keeps counter
   a_wr_on_keep: assert property (wr_cnt && st_r.cnt_en |=> st_r.preload ==
      $past(WRITEDATA[7:0]) && (st_r.count == $past(st_r.count) ||
      st_r.count == $past(st_r.count) + 8'h01 || st_r.wake))
      else $error("enabled write disturbed counter"); // RULE_19
   // RULE_20: read blocks counting
   a_read_block: assert property (rd_cnt_block |=> st_r.count == $past(st_r.count))
      else $error("counter moved during read"); // RULE_20
   // RULE_15: disabled counter stands
   a_off_hold: assert property (!st_r.cnt_en && !wr_cnt
      |=> st_r.count == $past(st_r.count) && !st_r.wake)
      else $error("disabled counter moved"); // RULE_15
   // RULE_11: measurement end clears enable
   a_pw_clear: assert property ($past(st_r.pw) == PW_COUNT && st_r.pw == PW_WAIT
      && !$past(wr_ctl) |-> !st_r.cnt_en)
      else $error("enable not cleared after measurement"); // RULE_11
   // RULE_21: unused bit reads zero
   a_bit5_zero: assert property ($fell(st_r.wait_q) && READ && ADDRESS == TEC0_ADDR_CTRL
      |-> !READDATA[TEC0_CTL_UNUSED_BIT])
      else $error("control bit 5 read as one"); // RULE_21
   a_bus_answer: assert property ((READ || WRITE) && st_r.wait_q |=> !st_r.wait_q ##1 st_r.wait_q)
      else $error("bus answer not after one wait cycle");
   // RULE_07: chosen edge adds one
   a_event_step: assert property (st_r.mode == TEC0_MODE_EVENT && st_r.cnt_en // RULE_07
      && !rd_cnt_block && (st_r.edge_sel ? pin_fall : pin_rise) && st_r.count != 8'hFF
      |=> st_r.count == $past(st_r.count) + 8'h01)
      else $error("event edge not counted once");
   // RULE_08: internal tick adds one
   a_timer_step: assert property (st_r.mode == TEC0_MODE_TIMER && st_r.cnt_en // RULE_08
      && !rd_cnt_block && int_tick && st_r.count != 8'hFF
      |=> st_r.count == $past(st_r.count) + 8'h01)
      else $error("timer tick not counted");
   // RULE_13: no start without an edge
   a_pw_no_level: assert property (st_r.pw == PW_WAIT && // RULE_13
      !(st_r.edge_sel ? pin_rise : pin_fall) |=> st_r.pw == PW_WAIT)
      else $error("measurement started without a start edge");
   // RULE_14: pulse mode overflow reloads
   a_pw_ovf: assert property (ovf && st_r.mode == TEC0_MODE_PULSE // RULE_14
      |=> st_r.count == $past(st_r.preload) && st_r.irq_flag && st_r.wake)
      else $error("pulse mode overflow did not reload");
   // RULE_22: one edge per pin change
   a_pin_once: assert property (pin_rise || pin_fall |=> !pin_rise && !pin_fall) // RULE_22
      else $error("pin change detected twice");
   // RULE_16: wake is a single pulse
   a_wake_pulse: assert property (st_r.wake |=> !st_r.wake) // RULE_16
      else $error("wake pulse longer than one cycle");

   c_overflow: cover property (st_r.wake);
   c_pw_done: cover property (st_r.pw == PW_COUNT ##1 st_r.pw == PW_WAIT);
   c_read_count: cover property (bus_done && READ && ADDRESS == TEC0_ADDR_COUNT);
   c_wr_running: cover property (wr_cnt && st_r.cnt_en);
   c_event_tick: cover property (st_r.mode == TEC0_MODE_EVENT && ev_tick);

endmodule : tec0_top

// ### design/tec0_pkg.sv
// Constants and types for timer/event counter 0.
// Assumes a 32-bit Avalon-MM slave port with byte addresses.
package tec0_pkg;

   // =====================================================================
   // Register map: printed indices, byte address is four times the index
   localparam logic [7:0] TEC0_IDX_COUNT = 8'h0D;
   localparam logic [7:0] TEC0_IDX_CTRL = 8'h0E;
   localparam logic [7:0] TEC0_IDX_IRQCTL = 8'h10;
   localparam logic [7:0] TEC0_ADDR_COUNT = 8'h34;
   localparam logic [7:0] TEC0_ADDR_CTRL = 8'h38;
   localparam logic [7:0] TEC0_ADDR_IRQCTL = 8'h40;
   localparam int TEC0_AW = 8;
   localparam int TEC0_DW = 32;

   // =====================================================================
   // Control register fields
   localparam int TEC0_CTL_PSC_LSB = 0;
   localparam int TEC0_CTL_PSC_MSB = 2;
   localparam int TEC0_CTL_EDGE_BIT = 3;
   localparam int TEC0_CTL_EN_BIT = 4;
   localparam int TEC0_CTL_UNUSED_BIT = 5;
   localparam int TEC0_CTL_MODE_LSB = 6;
   localparam int TEC0_CTL_MODE_MSB = 7;
   localparam int TEC0_IRQ_EN_BIT = 2;
   localparam int TEC0_IRQ_FLAG_BIT = 5;

   // =====================================================================
   // Modes, clock options and reset values
   localparam logic [1:0] TEC0_MODE_UNUSED = 2'h0;
   localparam logic [1:0] TEC0_MODE_EVENT = 2'h1;
   localparam logic [1:0] TEC0_MODE_TIMER = 2'h2;
   localparam logic [1:0] TEC0_MODE_PULSE = 2'h3;
   localparam logic [1:0] TEC0_SLOW_WDT = 2'h0;
   localparam logic [1:0] TEC0_SLOW_RTC = 2'h1;
   localparam logic [1:0] TEC0_SLOW_INSTR = 2'h2;
   localparam logic [7:0] TEC0_CTRL_RESET = 8'h08;
   localparam logic [7:0] TEC0_COUNT_RESET = 8'h00;
   localparam logic [7:0] TEC0_COUNT_MAX = 8'hFF;
   localparam logic [1:0] TEC0_SYS_DIV_LAST = 2'h3;
   // Divide by 16 then by 32 at code 000: 9 bits of the slow counter
   localparam logic [15:0] TEC0_PSC_MASK_MAX = 16'hFFFF;
   localparam logic [2:0] TEC0_PSC_CODE_MAX = 3'h7;

   typedef enum logic [0:0] {PW_WAIT, PW_COUNT} tec0_pw_e;

   typedef struct packed {
      logic [2:0] pin_s;
      logic pin_f;
      logic [2:0] wdt_s;
      logic wdt_f;
      logic [2:0] rtc_s;
      logic rtc_f;
      logic [1:0] div4;
      logic [15:0] slow_cnt;
      logic [7:0] count;
      logic [7:0] preload;
      logic [1:0] mode;
      logic edge_sel;
      logic cnt_en;
      logic [2:0] psc;
      tec0_pw_e pw;
      logic irq_flag;
      logic irq_en;
      logic irq_out;
      logic wake;
      logic wait_q;
      logic [7:0] rdata;
   } tec0_state_s;

endpackage : tec0_pkg

// ### tb/tec0_pin_model.sv
// Source of the external timer pin signal.
// Assumes go lasts one clock; idle is the resting level set by the bench.
`timescale 1ns/1ns
module tec0_pin_model (
   input wire logic clk,
   input wire logic idle,
   input wire logic go,
   input wire logic [15:0] width,
   output logic pin
);
   logic [15:0] left = 16'h0;

   // ==================================================================
   // Pulse of the level opposite to idle, width clocks long
   always_ff @(posedge clk) begin
      if (go) begin
         left <= width;
      end else if (left != 16'h0) begin
         left <= left - 16'h1;
      end
   end
   assign pin = (left != 16'h0) ? ~idle : idle;
endmodule : tec0_pin_model

// ### tb/timer_event_counter_zero_tb.sv
// Self-checking bench for timer/event counter 0.
// Assumes the slave answers after one wait cycle; straps change only while idle.
`timescale 1ns/1ns
module timer_event_counter_zero_tb;
   import tec0_pkg::*;
   logic REF_CLK = 1'b0;
   logic RESETN = 1'b0;
   logic READ = 1'b0;
   logic WRITE = 1'b0;
   logic [7:0] ADDRESS = 8'h00;
   logic [31:0] WRITEDATA = 32'h0;
   logic [3:0] BYTEENABLE = 4'hF;
   logic [31:0] READDATA;
   logic WAITREQUEST, TIMER_PIN, IRQ_REQ, WAKEUP;
   logic WATCHDOG_OSCILLATOR_IN = 1'b0;
   logic RTC_IN = 1'b0;
   logic CFG_INT_SLOW = 1'b0;
   logic [1:0] CFG_SLOW_SRC = TEC0_SLOW_INSTR;
   logic idle = 1'b0;
   logic go = 1'b0;
   logic [15:0] width = 16'h0;
   logic [31:0] seed = 32'd81503;
   logic [7:0] expq[$];
   int mismatches = 0;
   int n_compared = 0;
   int cycles = 0;
   int wakes = 0;

   tec0_top u_tec0_top (.REF_CLK(REF_CLK), .RESETN(RESETN), .ADDRESS(ADDRESS), .READ(READ),
      .WRITE(WRITE), .WRITEDATA(WRITEDATA), .BYTEENABLE(BYTEENABLE), .READDATA(READDATA),
      .WAITREQUEST(WAITREQUEST), .TIMER_PIN(TIMER_PIN), .WATCHDOG_OSCILLATOR_IN(WATCHDOG_OSCILLATOR_IN),
      .RTC_IN(RTC_IN), .CFG_SLOW_SRC(CFG_SLOW_SRC), .CFG_INT_SLOW(CFG_INT_SLOW),
      .IRQ_REQ(IRQ_REQ), .WAKEUP(WAKEUP));
   tec0_pin_model u_tec0_pin_model (.clk(REF_CLK), .idle(idle), .go(go), .width(width),
      .pin(TIMER_PIN));

   initial begin
      forever #5 REF_CLK = ~REF_CLK;
   end

   function automatic logic [31:0] xs(input logic [31:0] v);
      v ^= v << 13;
      v ^= v >> 17;
      v ^= v << 5;
      return v;
   endfunction : xs

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         mismatches++;
         $display("ERROR t=%0t seen=%h expected=%h", $time, seen, exp);
      end
   endtask : chk

   task automatic give_verdict;
      $display("compared %0d mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : give_verdict

   // ==================================================================
   // Bus master: hold the request until waitrequest is seen low
   task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] d);
      READ <= ~wr;
      WRITE <= wr;
      ADDRESS <= a;
      WRITEDATA <= {24'h0, d};
      @(posedge REF_CLK);
      while (WAITREQUEST !== 1'b0) @(posedge REF_CLK);
      READ <= 1'b0;
      WRITE <= 1'b0;
      @(posedge REF_CLK);
   endtask : bus

   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      expq.push_back(e);
      bus(1'b0, a, 8'h00);
   endtask : rd

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      bus(1'b1, a, d);
   endtask : wr

   task automatic pulse(input logic [15:0] w);
      go <= 1'b1;
      width <= w;
      @(posedge REF_CLK);
      go <= 1'b0;
      repeat (w + 16'd8) @(posedge REF_CLK);
   endtask : pulse

   // ==================================================================
   // Monitor: read data against the oldest noted expectation
   always @(posedge REF_CLK) begin
      cycles++;
      seed <= xs(seed);
      // Steady square of period 8 so the slow count is predictable
      RTC_IN <= cycles[2];
      WATCHDOG_OSCILLATOR_IN <= seed[9];
      if (WAKEUP === 1'b1) wakes++;
      if (READ && WAITREQUEST === 1'b0) chk(READDATA, {24'h0, expq.pop_front()});
      if (cycles > 60000) begin
         mismatches++;
         give_verdict();
      end
   end

   initial begin
      logic [7:0] r;
      int w0;
      repeat (10) @(posedge REF_CLK);
      RESETN <= 1'b1;
      @(posedge REF_CLK);
      rd(TEC0_ADDR_CTRL, TEC0_CTRL_RESET);
      wr(TEC0_ADDR_CTRL, 8'h2F);
      rd(TEC0_ADDR_CTRL, 8'h0F);
      rd(8'h44, 8'h00);
      BYTEENABLE <= 4'h0;
      wr(TEC0_ADDR_COUNT, 8'h77);
      BYTEENABLE <= 4'hF;
      rd(TEC0_ADDR_COUNT, TEC0_COUNT_RESET);
      $display("registers test done");
      // Event mode, rising edges, overflow with a random preload
      wr(TEC0_ADDR_CTRL, 8'h08);
      wr(TEC0_ADDR_COUNT, 8'hFD);
      rd(TEC0_ADDR_COUNT, 8'hFD);
      wr(TEC0_ADDR_CTRL, 8'h50);
      pulse(16'd3);
      pulse(16'd3);
      rd(TEC0_ADDR_COUNT, 8'hFF);
      r = seed[7:0];
      wr(TEC0_ADDR_COUNT, r);
      rd(TEC0_ADDR_COUNT, 8'hFF);
      w0 = wakes;
      pulse(16'd3);
      rd(TEC0_ADDR_COUNT, r);
      chk(wakes - w0, 1);
      rd(TEC0_ADDR_CTRL, 8'h50);
      rd(TEC0_ADDR_IRQCTL, 8'h20);
      chk(IRQ_REQ, 1'b0);
      wr(TEC0_ADDR_IRQCTL, 8'h24);
      repeat (2) @(posedge REF_CLK);
      chk(IRQ_REQ, 1'b1);
      wr(TEC0_ADDR_IRQCTL, 8'h04);
      repeat (2) @(posedge REF_CLK);
      chk(IRQ_REQ, 1'b0);
      $display("event rising test done");
      // Falling edge only, then mode 00 counts nothing
      wr(TEC0_ADDR_CTRL, 8'h08);
      wr(TEC0_ADDR_COUNT, 8'h00);
      wr(TEC0_ADDR_CTRL, 8'h58);
      idle <= 1'b1;
      repeat (8) @(posedge REF_CLK);
      rd(TEC0_ADDR_COUNT, 8'h00);
      idle <= 1'b0;
      repeat (8) @(posedge REF_CLK);
      rd(TEC0_ADDR_COUNT, 8'h01);
      wr(TEC0_ADDR_CTRL, 8'h10);
      pulse(16'd3);
      rd(TEC0_ADDR_COUNT, 8'h01);
      $display("event falling test done");
      // Timer mode on system clock over 4 reaches overflow
      wr(TEC0_ADDR_CTRL, 8'h08);
      wr(TEC0_ADDR_COUNT, 8'hF0);
      w0 = wakes;
      wr(TEC0_ADDR_CTRL, 8'h90);
      repeat (200) @(posedge REF_CLK);
      chk(wakes - w0 > 0, 1'b1);
      $display("timer test done");
      // Pulse width: measurement, hold, no start on a standing level, then a low pulse measured
      wr(TEC0_ADDR_CTRL, 8'h08);
      wr(TEC0_ADDR_COUNT, 8'h00);
      wr(TEC0_ADDR_CTRL, 8'hD8);
      pulse(16'd40);
      rd(TEC0_ADDR_COUNT, 8'h0A);
      rd(TEC0_ADDR_CTRL, 8'hC8);
      pulse(16'd40);
      rd(TEC0_ADDR_COUNT, 8'h0A);
      idle <= 1'b1;
      repeat (8) @(posedge REF_CLK);
      wr(TEC0_ADDR_CTRL, 8'hD8);
      repeat (20) @(posedge REF_CLK);
      rd(TEC0_ADDR_COUNT, 8'h0A);
      wr(TEC0_ADDR_CTRL, 8'h08);
      wr(TEC0_ADDR_COUNT, 8'h00);
      wr(TEC0_ADDR_CTRL, 8'hD0);
      pulse(16'd20);
      rd(TEC0_ADDR_COUNT, 8'h05);
      idle <= 1'b0;
      $display("pulse width test done");
      // Prescaled slow clock: codes 0 and 1 through a long pulse
      CFG_INT_SLOW <= 1'b1;
      for (int c = 0; c < 2; c++) begin
         wr(TEC0_ADDR_CTRL, 8'h08);
         wr(TEC0_ADDR_COUNT, 8'h00);
         wr(TEC0_ADDR_CTRL, 8'hD8 | 8'(c));
         pulse(16'd8192);
         rd(TEC0_ADDR_COUNT, 8'h04 >> c);
      end
      // RTC source: one slow tick per 8 clocks, one count per 4096 clocks
      CFG_SLOW_SRC <= TEC0_SLOW_RTC;
      wr(TEC0_ADDR_CTRL, 8'h08);
      wr(TEC0_ADDR_COUNT, 8'h00);
      wr(TEC0_ADDR_CTRL, 8'hD8);
      pulse(16'd8192);
      rd(TEC0_ADDR_COUNT, 8'h02);
      $display("prescaler test done");
      give_verdict();
   end
endmodule : timer_event_counter_zero_tb
